// ---- rtcpc_cfg.svh ----
// constants for the always-on power configuration block
// Operation
// - in the operating state the LAN sleep output stays high
// - low power, wake-LAN on, mains power: LAN sleep output driven low
// - with wake-LAN off the LAN sleep output is never asserted
// - low power on battery: battery qualifier bit decides LAN sleep assertion
// - suspend-to-RAM held at least 60us, 1ms, 125ms or 1s by field
// - suspend-to-disk width field selects 125us, 1s, 2s or 4s
// - disk select 0 gives a few clock periods, 1 applies the field
// - power-loss flag set while resume-well reset is active; write 1 clears
// - power-loss flag is reset only by the always-on reset
// - after power loss with policy 0 return to S0
// - with policy 1 return to S5, or S4 if the system was in S4
// - power-button override or thermal trip forces policy bit to 1
`ifndef RTCPC_CFG_SVH
`define RTCPC_CFG_SVH

`define RTCPC_ADDR_W        12
`define RTCPC_CFG_OFFSET    12'h008
`define RTCPC_CFG_BITS      9
`define RTCPC_CNT_W         28
`define RTCPC_LANE_LO       0
`define RTCPC_LANE_HI       1
`define RTCPC_BIT_HI        8

`define RTCPC_CLK_MHZ       50
`define RTCPC_RAM_W0_US     60
`define RTCPC_RAM_W1_US     1000
`define RTCPC_RAM_W2_US     125000
`define RTCPC_RAM_W3_US     1000000
`define RTCPC_DISK_W0_US    125
`define RTCPC_DISK_W1_US    1000000
`define RTCPC_DISK_W2_US    2000000
`define RTCPC_DISK_W3_US    4000000
`define RTCPC_DISK_SHORT_CYC 4

`endif

// ---- rtcpc_pkg.sv ----
// types shared by the always-on power configuration block
package rtcpc_pkg;

  typedef enum logic [1:0] {
    RTCPC_S0,
    RTCPC_S3,
    RTCPC_S4,
    RTCPC_S5
  } rtcpc_state_t;

  // layout matches the register bits 8 down to 0
  typedef struct packed {
    logic       wake_lan_enable;
    logic       wake_lan_battery_enable;
    logic [1:0] suspend_ram_min_width;
    logic [1:0] suspend_disk_min_width;
    logic       suspend_disk_width_select;
    logic       power_loss_flag;
    logic       power_restore_policy;
  } rtcpc_cfg_t;

endpackage : rtcpc_pkg

// ---- rtcpc_top.sv ----
// always-on power configuration register with sleep output sequencing
`timescale 1ns/1ns
`include "rtcpc_cfg.svh"

module rtcpc_top #(
  parameter int unsigned RAM_W1_CYC  = `RTCPC_RAM_W1_US * `RTCPC_CLK_MHZ,
  parameter int unsigned RAM_W2_CYC  = `RTCPC_RAM_W2_US * `RTCPC_CLK_MHZ,
  parameter int unsigned RAM_W3_CYC  = `RTCPC_RAM_W3_US * `RTCPC_CLK_MHZ,
  parameter int unsigned DISK_W0_CYC = `RTCPC_DISK_W0_US * `RTCPC_CLK_MHZ,
  parameter int unsigned DISK_W1_CYC = `RTCPC_DISK_W1_US * `RTCPC_CLK_MHZ,
  parameter int unsigned DISK_W2_CYC = `RTCPC_DISK_W2_US * `RTCPC_CLK_MHZ,
  parameter int unsigned DISK_W3_CYC = `RTCPC_DISK_W3_US * `RTCPC_CLK_MHZ
) (
  // clock and always-on reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // apb slave
  input  wire logic [`RTCPC_ADDR_W-1:0]   paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // system state and events
  input  wire rtcpc_pkg::rtcpc_state_t    sys_state,
  input  wire logic                       on_battery,
  input  wire logic                       pwrbtn_override,
  input  wire logic                       thermal_trip,
  input  wire logic                       resume_well_reset_n,
  // board side
  output logic                            lan_sleep_n,
  output logic                            suspend_ram_n,
  output logic                            suspend_disk_n,
  output logic                            restore_valid,
  output rtcpc_pkg::rtcpc_state_t         restore_state
);

  localparam int unsigned RAM_W0_CYC = `RTCPC_RAM_W0_US * `RTCPC_CLK_MHZ;
  localparam int unsigned CW         = `RTCPC_CNT_W;

  function automatic logic [CW-1:0] ram_cycles(input logic [1:0] sel);
    case (sel)
      2'h0:    ram_cycles = CW'(RAM_W0_CYC);
      2'h1:    ram_cycles = CW'(RAM_W1_CYC);
      2'h2:    ram_cycles = CW'(RAM_W2_CYC);
      default: ram_cycles = CW'(RAM_W3_CYC);
    endcase
  endfunction : ram_cycles

  function automatic logic [CW-1:0] disk_cycles(input logic en, input logic [1:0] sel);
    if (!en) begin
      disk_cycles = CW'(`RTCPC_DISK_SHORT_CYC);
    end else begin
      case (sel)
        2'h0:    disk_cycles = CW'(DISK_W0_CYC);
        2'h1:    disk_cycles = CW'(DISK_W1_CYC);
        2'h2:    disk_cycles = CW'(DISK_W2_CYC);
        default: disk_cycles = CW'(DISK_W3_CYC);
      endcase
    end
  endfunction : disk_cycles

  // registers
  rtcpc_pkg::rtcpc_cfg_t   cfg_reg;
  rtcpc_pkg::rtcpc_cfg_t   cfg_next;
  logic [31:0]             prdata_reg;
  logic                    pready_reg;
  logic                    pslverr_reg;
  logic                    lan_sleep_n_reg;
  logic                    ram_n_reg;
  logic                    disk_n_reg;
  logic [CW-1:0]           ram_cnt_reg;
  logic [CW-1:0]           disk_cnt_reg;
  logic                    rsm_prev_reg;
  logic                    was_s4_reg;
  logic                    restore_valid_reg;
  rtcpc_pkg::rtcpc_state_t restore_state_reg;

  // bus decode
  wire        hit       = (paddr == `RTCPC_CFG_OFFSET);
  wire        access    = psel & penable & pready_reg;
  wire        wr_hit    = access & pwrite & hit;
  wire        lane_lo   = pstrb[`RTCPC_LANE_LO];
  wire        lane_hi   = pstrb[`RTCPC_LANE_HI];
  wire [31:0] read_word = {{(32-`RTCPC_CFG_BITS){1'b0}}, cfg_reg};
  // write data seen through the register layout, so field positions live in one place
  wire rtcpc_pkg::rtcpc_cfg_t wr_cfg = pwdata[`RTCPC_CFG_BITS-1:0];

  // sleep requests
  wire low_power = (sys_state != rtcpc_pkg::RTCPC_S0);
  wire ram_req   = low_power;
  wire disk_req  = (sys_state == rtcpc_pkg::RTCPC_S4) | (sys_state == rtcpc_pkg::RTCPC_S5);
  wire lan_assert = low_power & cfg_reg.wake_lan_enable
                  & (on_battery ? cfg_reg.wake_lan_battery_enable : 1'b1);
  wire rsm_fall  = rsm_prev_reg & ~resume_well_reset_n;
  wire rsm_rise  = ~rsm_prev_reg & resume_well_reset_n;
  wire w1c_loss  = wr_hit & lane_lo & wr_cfg.power_loss_flag;

  // the struct walks bits 8..0; byte lanes gate the low and high bytes
  always_comb begin
    cfg_next = cfg_reg;
    if (wr_hit && lane_lo) begin
      cfg_next.wake_lan_battery_enable   = wr_cfg.wake_lan_battery_enable;
      cfg_next.suspend_ram_min_width     = wr_cfg.suspend_ram_min_width;
      cfg_next.suspend_disk_min_width    = wr_cfg.suspend_disk_min_width;
      cfg_next.suspend_disk_width_select = wr_cfg.suspend_disk_width_select;
      cfg_next.power_restore_policy      = wr_cfg.power_restore_policy;
    end
    if (wr_hit && lane_hi) begin
      cfg_next.wake_lan_enable = wr_cfg.wake_lan_enable;
    end
    // set beats the software clear when both land in one cycle
    if (w1c_loss) begin
      cfg_next.power_loss_flag = 1'b0;
    end
    if (!resume_well_reset_n) begin
      cfg_next.power_loss_flag = 1'b1;
    end
    if (pwrbtn_override || thermal_trip) begin
      cfg_next.power_restore_policy = 1'b1;
    end
  end

  // only the always-on reset touches this register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= '0;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= psel & penable & ~pready_reg;
      pslverr_reg <= psel & penable & ~pready_reg & ~hit;
      prdata_reg  <= (psel & penable & ~pready_reg & ~pwrite & hit) ? read_word : 32'h0000_0000;
    end
  end

  // counters run on the always-on clock so widths survive main power loss
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_n_reg    <= 1'b1;
      ram_cnt_reg  <= '0;
    end else if (ram_n_reg) begin
      if (ram_req) begin
        ram_n_reg   <= 1'b0;
        ram_cnt_reg <= ram_cycles(cfg_reg.suspend_ram_min_width) - CW'(1);
      end
    end else if (ram_cnt_reg != '0) begin
      ram_cnt_reg <= ram_cnt_reg - CW'(1);
    end else if (!ram_req) begin
      ram_n_reg <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disk_n_reg   <= 1'b1;
      disk_cnt_reg <= '0;
    end else if (disk_n_reg) begin
      if (disk_req) begin
        disk_n_reg   <= 1'b0;
        disk_cnt_reg <= disk_cycles(cfg_reg.suspend_disk_width_select,
                                    cfg_reg.suspend_disk_min_width) - CW'(1);
      end
    end else if (disk_cnt_reg != '0) begin
      disk_cnt_reg <= disk_cnt_reg - CW'(1);
    end else if (!disk_req) begin
      disk_n_reg <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lan_sleep_n_reg <= 1'b1;
    end else begin
      lan_sleep_n_reg <= ~lan_assert;
    end
  end

  // the state before the resume well collapsed picks the return target
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsm_prev_reg      <= 1'b1;
      was_s4_reg        <= 1'b0;
      restore_valid_reg <= 1'b0;
      restore_state_reg <= rtcpc_pkg::RTCPC_S0;
    end else begin
      rsm_prev_reg      <= resume_well_reset_n;
      restore_valid_reg <= rsm_rise & cfg_reg.power_loss_flag;
      if (rsm_fall) begin
        was_s4_reg <= (sys_state == rtcpc_pkg::RTCPC_S4);
      end
      if (rsm_rise && cfg_reg.power_loss_flag) begin
        if (!cfg_reg.power_restore_policy) begin
          restore_state_reg <= rtcpc_pkg::RTCPC_S0;
        end else if (was_s4_reg) begin
          restore_state_reg <= rtcpc_pkg::RTCPC_S4;
        end else begin
          restore_state_reg <= rtcpc_pkg::RTCPC_S5;
        end
      end
    end
  end

  assign prdata         = prdata_reg;
  assign pready         = pready_reg;
  assign pslverr        = pslverr_reg;
  assign lan_sleep_n    = lan_sleep_n_reg;
  assign suspend_ram_n  = ram_n_reg;
  assign suspend_disk_n = disk_n_reg;
  assign restore_valid  = restore_valid_reg;
  assign restore_state  = restore_state_reg;

  // helper logic for the width checks
  logic [CW-1:0] ram_low_cnt;
  logic [CW-1:0] disk_low_cnt;
  logic [CW-1:0] ram_need;
  logic [CW-1:0] disk_need;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_low_cnt  <= '0;
      disk_low_cnt <= '0;
      ram_need     <= '0;
      disk_need    <= '0;
    end else begin
      ram_low_cnt  <= ram_n_reg ? '0 : ram_low_cnt + CW'(1);
      disk_low_cnt <= disk_n_reg ? '0 : disk_low_cnt + CW'(1);
      if (ram_n_reg && ram_req) begin
        ram_need <= ram_cycles(cfg_reg.suspend_ram_min_width);
      end
      if (disk_n_reg && disk_req) begin
        disk_need <= disk_cycles(cfg_reg.suspend_disk_width_select,
                                 cfg_reg.suspend_disk_min_width);
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_lan_high_s0: assert property (
    sys_state == rtcpc_pkg::RTCPC_S0 |=> lan_sleep_n)
    else $error("lan sleep asserted in operating state");

  a_lan_low_mains: assert property (
    low_power && cfg_reg.wake_lan_enable && !on_battery |=> !lan_sleep_n)
    else $error("lan sleep not asserted on mains power");

  a_lan_off_never: assert property (
    !cfg_reg.wake_lan_enable |=> lan_sleep_n)
    else $error("lan sleep asserted with wake disabled");

  a_lan_battery_qual: assert property (
    low_power && cfg_reg.wake_lan_enable && on_battery
    |=> lan_sleep_n == !$past(cfg_reg.wake_lan_battery_enable))
    else $error("battery qualifier ignored");

  a_ram_min_width: assert property (
    $rose(suspend_ram_n) |-> ram_low_cnt >= ram_need)
    else $error("suspend to ram released too early");

  a_disk_min_width: assert property (
    $rose(suspend_disk_n) |-> disk_low_cnt >= disk_need)
    else $error("suspend to disk released too early");

  a_disk_short_pulse: assert property (
    $fell(suspend_disk_n) && !$past(cfg_reg.suspend_disk_width_select) && !disk_req
    |-> !suspend_disk_n [*4] ##1 suspend_disk_n)
    else $error("short disk width not applied");

  a_loss_set: assert property (
    !resume_well_reset_n |=> cfg_reg.power_loss_flag)
    else $error("power loss flag not set");

  a_loss_cleared: assert property (
    cfg_reg.power_loss_flag && resume_well_reset_n && w1c_loss
    |=> !cfg_reg.power_loss_flag)
    else $error("power loss flag not cleared by write one");

  a_restore_s0: assert property (
    rsm_rise && cfg_reg.power_loss_flag && !cfg_reg.power_restore_policy
    |=> restore_valid && restore_state == rtcpc_pkg::RTCPC_S0)
    else $error("restore target not S0");

  a_restore_s4_s5: assert property (
    rsm_rise && cfg_reg.power_loss_flag && cfg_reg.power_restore_policy
    |=> restore_valid && restore_state == ($past(was_s4_reg) ?
        rtcpc_pkg::RTCPC_S4 : rtcpc_pkg::RTCPC_S5))
    else $error("restore target not S4 or S5");

  a_policy_forced: assert property (
    pwrbtn_override || thermal_trip |=> cfg_reg.power_restore_policy)
    else $error("policy bit not forced by event");

  a_reserved_zero: assert property (
    pready && !pslverr |-> prdata[31:`RTCPC_CFG_BITS] == '0)
    else $error("reserved bits read nonzero");

  a_bus_answer: assert property (
    psel && penable && !pready |=> pready)
    else $error("slave did not answer in one wait state");

  a_ram_asserts: assert property (
    ram_req && suspend_ram_n |=> !suspend_ram_n)
    else $error("suspend to ram not asserted on request");

  a_disk_asserts: assert property (
    disk_req && suspend_disk_n |=> !suspend_disk_n)
    else $error("suspend to disk not asserted on request");

  a_flag_hold: assert property (
    cfg_reg.power_loss_flag && !w1c_loss |=> cfg_reg.power_loss_flag)
    else $error("power loss flag lost without write one");

  a_restore_quiet: assert property (
    !(rsm_rise && cfg_reg.power_loss_flag) |=> !restore_valid)
    else $error("restore pulse without power return");

  c_lan_battery: cover property (
    low_power && cfg_reg.wake_lan_enable && on_battery ##1 !lan_sleep_n);

  c_ram_cycle: cover property (
    $fell(suspend_ram_n) ##[1:1000] $rose(suspend_ram_n));

  c_restore_s4: cover property (
    restore_valid && restore_state == rtcpc_pkg::RTCPC_S4);

  c_loss_write_clear: cover property (
    cfg_reg.power_loss_flag && w1c_loss ##1 !cfg_reg.power_loss_flag);

endmodule : rtcpc_top

// ---- rtcpc_board.sv ----
// board supply and sleep-width monitor model for the power config block
`timescale 1ns/1ns
module rtcpc_board (
  // clock
  input  wire logic        pclk,
  // supply commands
  input  wire logic        supply_fail,
  input  wire logic        use_battery,
  // sleep outputs watched
  input  wire logic        suspend_ram_n,
  input  wire logic        suspend_disk_n,
  // supply status
  output logic             resume_well_reset_n,
  output logic             on_battery,
  // length of the last low pulse, in clock cycles
  output logic [31:0]      ram_low_len,
  output logic [31:0]      disk_low_len
);
  logic [31:0] ram_cnt;
  logic [31:0] disk_cnt;

  // the resume well has no pull, so it follows the supply directly
  assign resume_well_reset_n = ~supply_fail;
  assign on_battery          = use_battery;

  always_ff @(posedge pclk) begin
    ram_cnt  <= suspend_ram_n ? 32'h0 : ram_cnt + 32'h1;
    disk_cnt <= suspend_disk_n ? 32'h0 : disk_cnt + 32'h1;
    if (suspend_ram_n && ram_cnt != 32'h0) ram_low_len <= ram_cnt;
    if (suspend_disk_n && disk_cnt != 32'h0) disk_low_len <= disk_cnt;
  end
endmodule : rtcpc_board

// ---- rtc_domain_power_config_bench.sv ----
// self-checking bench for the always-on power config block
`timescale 1ns/1ns
module rtc_domain_power_config_bench;
  localparam int R1 = 20, R2 = 30, R3 = 40;
  localparam int D0 = 12, D1 = 16, D2 = 24, D3 = 36;
  localparam int R0 = 60 * 50;
  localparam int SHORT = 4;
  localparam logic [11:0] ADDR = 12'h008;

  logic                    pclk, presetn, psel, penable, pwrite;
  logic [11:0]             paddr;
  logic [31:0]             pwdata, prdata, q, ram_len, disk_len;
  logic [3:0]              pstrb;
  logic                    pready, pslverr, e, fail, batt, on_batt, rwr_n;
  logic                    pwrbtn, trip, lan_n, ram_n, disk_n, rvalid;
  rtcpc_pkg::rtcpc_state_t st, rstate;
  int                      n_fail, tests_run, cyc;

  rtcpc_top #(.RAM_W1_CYC(R1), .RAM_W2_CYC(R2), .RAM_W3_CYC(R3), .DISK_W0_CYC(D0),
              .DISK_W1_CYC(D1), .DISK_W2_CYC(D2), .DISK_W3_CYC(D3)) uut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sys_state(st), .on_battery(on_batt),
    .pwrbtn_override(pwrbtn), .thermal_trip(trip), .resume_well_reset_n(rwr_n),
    .lan_sleep_n(lan_n), .suspend_ram_n(ram_n), .suspend_disk_n(disk_n),
    .restore_valid(rvalid), .restore_state(rstate));

  rtcpc_board board (
    .pclk(pclk), .supply_fail(fail), .use_battery(batt), .suspend_ram_n(ram_n),
    .suspend_disk_n(disk_n), .resume_well_reset_n(rwr_n), .on_battery(on_batt),
    .ram_low_len(ram_len), .disk_low_len(disk_len));

  task automatic test_done;
    if (n_fail == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : chk

  // one transfer; ends one idle cycle after completion so drivers never collide
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic t_regs;
    apb(1'b0, ADDR, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, ADDR, 32'hFFFF_FFFF);
    apb(1'b0, ADDR, 32'h0);
    chk(q, 32'h0000_01FD);
    chk({31'h0, e}, 32'h0);
    apb(1'b1, 12'h00C, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 12'h00C, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    apb(1'b0, ADDR, 32'h0);
    chk(q, 32'h0000_01FD);
    apb(1'b1, ADDR, 32'h0);
  endtask : t_regs

  task automatic t_lan;
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, ADDR, {23'h0, i[0], i[1], 7'h20});
      st <= i[2] ? rtcpc_pkg::RTCPC_S3 : rtcpc_pkg::RTCPC_S0;
      batt <= i[3];
      repeat (3) @(posedge pclk);
      chk({31'h0, lan_n}, {31'h0, !(i[2] && i[0] && (!i[3] || i[1]))});
    end
    st <= rtcpc_pkg::RTCPC_S0;
    batt <= 1'b0;
    repeat (60) @(posedge pclk);
  endtask : t_lan

  // a one-cycle S4 request shows the bare minimum width on both outputs
  task automatic t_width(input logic [1:0] rf, input logic [1:0] df, input logic sel,
                         input int er, input int ed);
    int n;
    n = 0;
    apb(1'b1, ADDR, {25'h0, rf, df, sel, 2'b00});
    st <= rtcpc_pkg::RTCPC_S4;
    @(posedge pclk);
    st <= rtcpc_pkg::RTCPC_S0;
    repeat (3) @(posedge pclk);
    while (!(ram_n === 1'b1 && disk_n === 1'b1) && n < 4000) begin
      @(posedge pclk);
      n++;
    end
    // a wait that ran out shows up here as outputs still asserted
    chk({31'h0, ram_n & disk_n}, 32'h1);
    repeat (2) @(posedge pclk);
    chk(ram_len, er);
    chk(disk_len, ed);
  endtask : t_width

  task automatic t_loss(input logic pol, input rtcpc_pkg::rtcpc_state_t s,
                        input rtcpc_pkg::rtcpc_state_t x);
    int n;
    n = 0;
    apb(1'b1, ADDR, {31'h0, pol});
    st <= s;
    @(posedge pclk);
    fail <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, ADDR, 32'h0);
    chk(q, {30'h0, 1'b1, pol});
    fail <= 1'b0;
    @(posedge pclk);
    while (rvalid !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk({29'h0, rvalid, rstate}, {29'h0, 1'b1, x});
    @(posedge pclk);
    chk({31'h0, rvalid}, 32'h0);
    st <= rtcpc_pkg::RTCPC_S0;
    apb(1'b0, ADDR, 32'h0);
    chk({31'h0, q[1]}, 32'h1);
    apb(1'b1, ADDR, 32'h2);
    apb(1'b0, ADDR, 32'h0);
    chk(q, 32'h0);
  endtask : t_loss

  task automatic t_policy;
    apb(1'b1, ADDR, 32'h0);
    pwrbtn <= 1'b1;
    @(posedge pclk);
    pwrbtn <= 1'b0;
    apb(1'b0, ADDR, 32'h0);
    chk(q, 32'h1);
    apb(1'b1, ADDR, 32'h0);
    trip <= 1'b1;
    @(posedge pclk);
    trip <= 1'b0;
    apb(1'b0, ADDR, 32'h0);
    chk(q, 32'h1);
  endtask : t_policy

  // a write-one clear while the resume well is down loses to the set; only presetn clears
  task automatic t_rst;
    fail <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b1, ADDR, 32'h0000_0002);
    apb(1'b0, ADDR, 32'h0);
    chk(q, 32'h0000_0002);
    fail <= 1'b0;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ADDR, 32'h0);
    chk(q, 32'h0);
  endtask : t_rst

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // the longest scenario waits a few thousand cycles; this ceiling leaves margin
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end

  initial begin
    n_fail = 0;
    tests_run = 0;
    cyc = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    fail = 1'b0;
    batt = 1'b0;
    pwrbtn = 1'b0;
    trip = 1'b0;
    st = rtcpc_pkg::RTCPC_S0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_lan();
    t_width(2'b00, 2'b00, 1'b1, R0, D0);
    t_width(2'b01, 2'b01, 1'b1, R1, D1);
    t_width(2'b10, 2'b10, 1'b1, R2, D2);
    t_width(2'b11, 2'b11, 1'b1, R3, D3);
    t_width(2'b01, 2'b11, 1'b0, R1, SHORT);
    // each restore target differs from the one before, so a stale target cannot pass
    t_loss(1'b1, rtcpc_pkg::RTCPC_S4, rtcpc_pkg::RTCPC_S4);
    t_loss(1'b1, rtcpc_pkg::RTCPC_S5, rtcpc_pkg::RTCPC_S5);
    t_loss(1'b0, rtcpc_pkg::RTCPC_S3, rtcpc_pkg::RTCPC_S0);
    t_policy();
    t_rst();
    test_done();
  end
endmodule : rtc_domain_power_config_bench
